// File: inc/bcd_map.svh
`ifndef BCD_MAP_SVH
`define BCD_MAP_SVH
// Opcode bytes
`define BCD_OP_JCC_HI 4'h7
`define BCD_OP_LOOP 8'hE2
`define BCD_OP_LOOPEQ 8'hE1
`define BCD_OP_LOOPNE 8'hE0
`define BCD_OP_JCZ 8'hE3
`define BCD_OP_OVTRAP 8'hCE
`define BCD_OP_INTERRUPT_RETURN 8'hCF
`define BCD_OP_RANGE 8'h62
`define BCD_OP_CCLR 8'hF8
`define BCD_OP_CINV 8'hF5
`define BCD_OP_CSET 8'hF9
`define BCD_OP_DCLR 8'hFC
`define BCD_OP_DSET 8'hFD
`define BCD_OP_IMASK 8'hFA
`define BCD_OP_IUNMASK 8'hFB
`define BCD_OP_ESC_HI 5'h1B
`define BCD_OP_TWO 8'h0F
`define BCD_OP_TBL 8'h01
`define BCD_RANGE_VEC 8'h05
// Segment codes
`define BCD_SEG_EXTRA 2'h0
`define BCD_SEG_CODE 2'h1
`define BCD_SEG_STACK 2'h2
`define BCD_SEG_DATA 2'h3
// Clock counts, base part (taken counts add m)
`define BCD_CLK_JCC_T 8'h07
`define BCD_CLK_JCC_N 8'h03
`define BCD_CLK_LOOP_T 8'h08
`define BCD_CLK_LOOP_N 8'h04
`define BCD_CLK_TRAP_T 8'h18
`define BCD_CLK_TRAP_N 8'h03
`define BCD_CLK_INTERRUPT_RETURN_R 8'h11
`define BCD_CLK_INTERRUPT_RETURN_P 8'h1F
`define BCD_CLK_INTERRUPT_RETURN_PL 8'h37
`define BCD_CLK_INTERRUPT_RETURN_TS 8'hA9
`define BCD_CLK_RANGE 8'h0D
`define BCD_CLK_INT 8'h17
`define BCD_CLK_FLAG 8'h02
`define BCD_CLK_IMASK 8'h03
`define BCD_CLK_ESC_MIN 8'h09
`define BCD_CLK_ESC_MAX 8'h14
`define BCD_CLK_TBL 8'h0C
`endif

// File: inc/bcd_pkg.sv
package bcd_pkg;
  typedef enum logic [4:0] {
    BCD_K_NONE, BCD_K_JCC, BCD_K_LOOP, BCD_K_LOOPEQ, BCD_K_LOOPNE,
    BCD_K_JCZ, BCD_K_OVTRAP, BCD_K_INTERRUPT_RETURN, BCD_K_RANGE, BCD_K_CCLR,
    BCD_K_CINV, BCD_K_CSET, BCD_K_DCLR, BCD_K_DSET, BCD_K_IMASK,
    BCD_K_IUNMASK, BCD_K_ESC, BCD_K_GLOAD, BCD_K_GSTORE, BCD_K_VLOAD,
    BCD_K_VSTORE, BCD_K_PREFIX
  } bcd_kind_t;
  typedef enum logic [1:0] {
    BCD_D_NONE, BCD_D_BYTE, BCD_D_WORD, BCD_D_DIRECT
  } bcd_disp_t;
  // CPU state sampled with each instruction
  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic ovf;
    logic parity;
    logic nested_task_flag;
    logic prot_mode;
    logic priv_change;
    logic count_is_one;
    logic count_is_zero;
    logic range_ok;
  } bcd_state_t;
  // Decoded result
  typedef struct packed {
    bcd_kind_t kind;
    logic taken;
    logic add_m;
    logic [7:0] clocks;
    logic [7:0] clocks_max;
    logic [7:0] vector;
    logic [5:0] ext_op;
    logic [2:0] rm_reg;
    logic rm_is_reg;
    logic [3:0] reg_sel;
    bcd_disp_t disp_form;
    logic [15:0] disp;
    logic [1:0] seg;
    logic [1:0] dst_seg;
    logic [2:0] flag_op;
  } bcd_dec_t;
endpackage

// File: rtl/bcd_decoder.sv
// Purpose: Decodes branch, loop, trap, flag, escape, prefix and table
//          opcodes plus mod/reg/rm operand addressing.
// Assumes: Bytes 0..3 of one instruction are presented together with
//          INS_VALID; a prefix is presented alone first.
// Notes:   Results appear one clock after INS_VALID and stand one cycle.
//
// How it works
// - Opcode 0111cccc decodes sixteen conditional short jumps by condition code.
// - Opcode E2 decrements count, branches if nonzero; 8+m taken, 4 not.
// - E1 loops while count nonzero and zero set; E0 while zero clear.
// - E3 branches only when count register is zero; 8+m or 4.
// - CE traps only if overflow set; 24+m taken, else 3.
// - CF returns from interrupt; 17+m real, 31+m protected.
// - Protected return with nested task does task switch 169+m; privilege 55+m.
// - Range check 62 costs 13; out of range raises vector 5, interrupt timing.
// - F8, F5, F9 clear, invert, set carry in 2 clocks.
// - FC clears, FD sets direction flag, each 2 clocks.
// - FA clears interrupt enable in 3 clocks; FB sets in 2.
// - 11011xxx plus mod reg bits form extension opcode; 9 to 20 clocks.
// - Prefix 001ss110 overrides next operand segment, zero clocks.
// - 0F 01 with reg 010 loads, 000 stores global table.
// - 0F 01 with reg 011 loads, 001 stores vector table; 12 clocks.
// - Mode 11 makes the r/m field a register selector.
// - Mode 00 has no displacement, except r/m 110 direct 16-bit address.
// - Mode 01 sign-extends one byte; mode 10 takes low then high byte.
// - Displacement bytes directly follow the mod byte (third byte for 0F 01), before immediates.
// - Register field picks word or byte registers by width bit.
// - Operands addressed through base pointer default to stack segment.
// - String destination via destination index always uses extra segment.
`include "bcd_map.svh"

module bcd_decoder
  import bcd_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic INS_VALID,
  input wire logic [31:0] INS_BYTES,
  input wire logic WIDTH_BIT,
  input wire logic STRING_DST,
  input wire bcd_state_t CPU_STATE,
  output bcd_dec_t DEC_OUT,
  output logic DEC_VALID
);

  wire [7:0] op = INS_BYTES[7:0];
  wire [7:0] b1 = INS_BYTES[15:8];
  wire [7:0] b2 = INS_BYTES[23:16];
  wire [7:0] b3 = INS_BYTES[31:24];
  wire [1:0] mode = b1[7:6];
  wire [2:0] mreg = b1[5:3];
  wire [2:0] rm = b1[2:0];
  wire [1:0] tmode = b2[7:6];
  wire [2:0] treg = b2[5:3];
  wire [2:0] trm = b2[2:0];

  // Pending segment override from a prefix byte
  logic ovr_r;
  logic ovr_nxt;
  logic [1:0] ovr_seg_r;
  logic [1:0] ovr_seg_nxt;

  // Condition evaluation for short jumps
  wire [2:0] cc = op[3:1];
  logic cond_raw;
  always_comb
  begin
    unique case (cc)
      3'h0: cond_raw = CPU_STATE.ovf;
      3'h1: cond_raw = CPU_STATE.carry;
      3'h2: cond_raw = CPU_STATE.zero;
      3'h3: cond_raw = CPU_STATE.carry | CPU_STATE.zero;
      3'h4: cond_raw = CPU_STATE.sign;
      3'h5: cond_raw = CPU_STATE.parity;
      3'h6: cond_raw = CPU_STATE.sign ^ CPU_STATE.ovf;
      3'h7: cond_raw = (CPU_STATE.sign ^ CPU_STATE.ovf) | CPU_STATE.zero;
    endcase
  end
  wire jcc_taken = cond_raw ^ op[0];

  // Loop exit looks at the count after decrement
  wire cnt_after_nz = ~CPU_STATE.count_is_one;
  wire loop_t = cnt_after_nz;
  wire loopeq_t = cnt_after_nz & CPU_STATE.zero;
  wire loopne_t = cnt_after_nz & ~CPU_STATE.zero;
  wire jcz_t = CPU_STATE.count_is_zero;

  // Opcode classification
  wire is_jcc = (op[7:4] == `BCD_OP_JCC_HI);
  wire is_esc = (op[7:3] == `BCD_OP_ESC_HI);
  wire is_pfx = (op[7:5] == 3'h1) && (op[2:0] == 3'h6);
  wire is_tbl = (op == `BCD_OP_TWO) && (b1 == `BCD_OP_TBL);
  wire uses_modrm = is_esc || (op == `BCD_OP_RANGE);

  bcd_kind_t kind;
  logic taken;
  logic add_m;
  logic [7:0] clk_n;
  logic [7:0] clk_max;
  logic [7:0] vec;
  always_comb
  begin
    kind = BCD_K_NONE;
    taken = 1'b0;
    add_m = 1'b0;
    clk_n = 8'h00;
    clk_max = 8'h00;
    vec = 8'h00;
    if (is_jcc)
    begin
      kind = BCD_K_JCC;
      taken = jcc_taken;
    end
    else if (is_esc)
    begin
      kind = BCD_K_ESC;
      clk_n = `BCD_CLK_ESC_MIN;
      clk_max = `BCD_CLK_ESC_MAX;
    end
    else if (is_pfx)
      kind = BCD_K_PREFIX;
    else if (is_tbl)
    begin
      clk_n = `BCD_CLK_TBL;
      unique case (treg)
        3'h2: kind = BCD_K_GLOAD;
        3'h0: kind = BCD_K_GSTORE;
        3'h3: kind = BCD_K_VLOAD;
        3'h1: kind = BCD_K_VSTORE;
        default: kind = BCD_K_NONE;
      endcase
    end
    else
    begin
      unique case (op)
        `BCD_OP_LOOP: begin kind = BCD_K_LOOP; taken = loop_t; end
        `BCD_OP_LOOPEQ: begin kind = BCD_K_LOOPEQ; taken = loopeq_t; end
        `BCD_OP_LOOPNE: begin kind = BCD_K_LOOPNE; taken = loopne_t; end
        `BCD_OP_JCZ: begin kind = BCD_K_JCZ; taken = jcz_t; end
        `BCD_OP_OVTRAP:
        begin
          kind = BCD_K_OVTRAP;
          taken = CPU_STATE.ovf;
          add_m = CPU_STATE.ovf;
          clk_n = CPU_STATE.ovf ? `BCD_CLK_TRAP_T : `BCD_CLK_TRAP_N;
          vec = 8'h04;
        end
        `BCD_OP_INTERRUPT_RETURN:
        begin
          kind = BCD_K_INTERRUPT_RETURN;
          add_m = 1'b1;
          if (!CPU_STATE.prot_mode)
            clk_n = `BCD_CLK_INTERRUPT_RETURN_R;
          else if (CPU_STATE.nested_task_flag)
            clk_n = `BCD_CLK_INTERRUPT_RETURN_TS;
          else if (CPU_STATE.priv_change)
            clk_n = `BCD_CLK_INTERRUPT_RETURN_PL;
          else
            clk_n = `BCD_CLK_INTERRUPT_RETURN_P;
        end
        `BCD_OP_RANGE:
        begin
          kind = BCD_K_RANGE;
          taken = ~CPU_STATE.range_ok;
          add_m = ~CPU_STATE.range_ok;
          clk_n = CPU_STATE.range_ok ? `BCD_CLK_RANGE : `BCD_CLK_INT;
          vec = CPU_STATE.range_ok ? 8'h00 : `BCD_RANGE_VEC;
        end
        `BCD_OP_CCLR: begin kind = BCD_K_CCLR; clk_n = `BCD_CLK_FLAG; end
        `BCD_OP_CINV: begin kind = BCD_K_CINV; clk_n = `BCD_CLK_FLAG; end
        `BCD_OP_CSET: begin kind = BCD_K_CSET; clk_n = `BCD_CLK_FLAG; end
        `BCD_OP_DCLR: begin kind = BCD_K_DCLR; clk_n = `BCD_CLK_FLAG; end
        `BCD_OP_DSET: begin kind = BCD_K_DSET; clk_n = `BCD_CLK_FLAG; end
        `BCD_OP_IMASK: begin kind = BCD_K_IMASK; clk_n = `BCD_CLK_IMASK; end
        `BCD_OP_IUNMASK:
        begin
          kind = BCD_K_IUNMASK;
          clk_n = `BCD_CLK_FLAG;
        end
        default: kind = BCD_K_NONE;
      endcase
    end
    // Branch timing: long count plus m when taken, short otherwise
    if (kind == BCD_K_JCC)
    begin
      add_m = taken;
      clk_n = taken ? `BCD_CLK_JCC_T : `BCD_CLK_JCC_N;
    end
    else if (kind inside {BCD_K_LOOP, BCD_K_LOOPEQ, BCD_K_LOOPNE, BCD_K_JCZ})
    begin
      add_m = taken;
      clk_n = taken ? `BCD_CLK_LOOP_T : `BCD_CLK_LOOP_N;
    end
  end
  // Flag action code: bit2 set for direction and irq ops, bits differ per op
  logic [2:0] fop;
  always_comb
  begin
    unique case (kind)
      BCD_K_CCLR: fop = 3'h1;
      BCD_K_CINV: fop = 3'h2;
      BCD_K_CSET: fop = 3'h3;
      BCD_K_DCLR: fop = 3'h4;
      BCD_K_DSET: fop = 3'h5;
      BCD_K_IMASK: fop = 3'h6;
      BCD_K_IUNMASK: fop = 3'h7;
      default: fop = 3'h0;
    endcase
  end
  // Operand addressing from the mod byte; table ops use the third byte
  wire [1:0] amode = is_tbl ? tmode : mode;
  wire [2:0] arm = is_tbl ? trm : rm;
  wire [7:0] dlo = is_tbl ? b3 : b2; // Disp right after the mod byte
  wire [7:0] dhi = is_tbl ? 8'h00 : b3;
  wire direct = (amode == 2'h0) && (arm == 3'h6);
  bcd_disp_t dform;
  logic [15:0] dval;
  always_comb
  begin
    unique case (amode)
      2'h0:
      begin
        dform = direct ? BCD_D_DIRECT : BCD_D_NONE;
        dval = direct ? {dhi, dlo} : 16'h0000;
      end
      2'h1:
      begin
        dform = BCD_D_BYTE;
        dval = {{8{dlo[7]}}, dlo};
      end
      2'h2:
      begin
        dform = BCD_D_WORD;
        dval = {dhi, dlo};
      end
      2'h3:
      begin
        dform = BCD_D_NONE;
        dval = 16'h0000;
      end
    endcase
  end
  wire rm_reg = (amode == 2'h3);
  // Bit3 is the width bit: 1 = word registers, 0 = byte registers
  wire [3:0] reg_sel = {WIDTH_BIT, mreg};

  // Base pointer forms: rm 010, 011, and 110 unless direct
  wire via_bp = ~rm_reg && ((arm == 3'h2) || (arm == 3'h3) ||
                ((arm == 3'h6) && !direct));
  wire [1:0] def_seg = via_bp ? `BCD_SEG_STACK : `BCD_SEG_DATA;
  wire [1:0] seg = ovr_r ? ovr_seg_r : def_seg;
  // Override never reaches the string destination
  wire [1:0] dst_seg = `BCD_SEG_EXTRA;

  bcd_dec_t dec_nxt;
  always_comb
  begin
    dec_nxt = '0;
    dec_nxt.kind = kind;
    dec_nxt.taken = taken;
    dec_nxt.add_m = add_m;
    dec_nxt.clocks = clk_n;
    dec_nxt.clocks_max = (kind == BCD_K_ESC) ? clk_max : clk_n;
    dec_nxt.vector = vec;
    dec_nxt.ext_op = {op[2:0], mreg};
    dec_nxt.rm_reg = arm;
    dec_nxt.rm_is_reg = rm_reg;
    dec_nxt.reg_sel = reg_sel;
    dec_nxt.disp_form = (uses_modrm || is_tbl) ? dform : BCD_D_NONE;
    dec_nxt.disp = (uses_modrm || is_tbl) ? dval : 16'h0000;
    dec_nxt.seg = STRING_DST ? dst_seg : seg;
    dec_nxt.dst_seg = dst_seg;
    dec_nxt.flag_op = fop;
  end

  // Prefix persists until the next real instruction consumes it
  assign ovr_nxt = INS_VALID ? is_pfx : ovr_r;
  assign ovr_seg_nxt = (INS_VALID && is_pfx) ? op[4:3] : ovr_seg_r;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      ovr_r <= 1'b0;
      ovr_seg_r <= 2'h0;
      DEC_OUT <= '0;
      DEC_VALID <= 1'b0;
    end
    else
    begin
      ovr_r <= ovr_nxt;
      ovr_seg_r <= ovr_seg_nxt;
      DEC_OUT <= INS_VALID ? dec_nxt : '0;
      DEC_VALID <= INS_VALID;
    end
  end

  // Checks beside the logic
  a_trap_cost: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) INS_VALID && op == `BCD_OP_OVTRAP |=>
    DEC_OUT.clocks == ($past(CPU_STATE.ovf) ? 8'h18 : 8'h03))
    else $error("trap clock count wrong");
  a_loop_cost: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) DEC_VALID && DEC_OUT.kind == BCD_K_LOOP |->
    DEC_OUT.clocks == (DEC_OUT.taken ? 8'h08 : 8'h04))
    else $error("loop clock count wrong");
  a_jcz_taken: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) INS_VALID && op == `BCD_OP_JCZ |=>
    DEC_OUT.taken == $past(CPU_STATE.count_is_zero))
    else $error("counter zero jump wrong");
  a_interrupt_return_task: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) INS_VALID && op == `BCD_OP_INTERRUPT_RETURN &&
    CPU_STATE.prot_mode && CPU_STATE.nested_task_flag |=>
    DEC_OUT.clocks == 8'hA9)
    else $error("task switch return count wrong");
  a_jump_m: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) DEC_VALID && DEC_OUT.kind == BCD_K_JCC |->
    DEC_OUT.add_m == DEC_OUT.taken &&
    DEC_OUT.clocks == (DEC_OUT.taken ? 8'h07 : 8'h03))
    else $error("m term wrong");
  a_range_vec: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) INS_VALID && op == `BCD_OP_RANGE &&
    !CPU_STATE.range_ok |=> DEC_OUT.vector == 8'h05 && DEC_OUT.clocks == 8'h17)
    else $error("range exception wrong");
  a_dst_extra: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) INS_VALID && STRING_DST |=> DEC_OUT.seg == 2'h0)
    else $error("string destination segment wrong");
  a_bp_stack: assert property (@(posedge CORE_CLK)
    disable iff (!RST_N) INS_VALID && op == `BCD_OP_RANGE && !ovr_r &&
    !STRING_DST && b1[7:6] == 2'h1 && b1[2:0] == 3'h6 |=> DEC_OUT.seg == 2'h2)
    else $error("base pointer segment wrong");
  c_jump_taken: cover property (@(posedge CORE_CLK)
    DEC_VALID && DEC_OUT.kind == BCD_K_JCC && DEC_OUT.taken);
  c_prefix_use: cover property (@(posedge CORE_CLK)
    INS_VALID && is_pfx ##1 INS_VALID && !is_pfx);
  c_trap: cover property (@(posedge CORE_CLK)
    DEC_VALID && DEC_OUT.kind == BCD_K_OVTRAP && DEC_OUT.taken);
endmodule

// File: tb/bcd_mem_model.sv
// Purpose: Program memory that feeds instruction words to the decoder.
// Assumes: One 32-bit word per slot, opcode in the low byte.
// Notes:   A released bus shows the inverted word, never a stale copy.
module bcd_mem_model
  import bcd_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [3:0] addr,
  input wire logic [31:0] wr_word,
  input wire logic rd_en,
  output logic [31:0] bytes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem_r [16];
  // Words hold opcode, mod byte, then displacement low and high
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem_r[addr] <= wr_word;
  end
  // Inversion when idle so that the decoder cannot lean on old bytes
  assign bytes = rd_en ? mem_r[addr] : ~mem_r[addr];
endmodule

// File: tb/test_cpu_branch_control_decoder.sv
// Purpose: Self-checking bench for the branch and addressing decoder.
// Assumes: Result stands one cycle after the edge that takes it.
// Notes:   Expectations come from flag tables written here by hand.
`define CHK(a, b) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      $display("wrong value at %0t: %h vs %h", $time, (a), (b)); \
      n_errors++; \
    end \
  end

module test_cpu_branch_control_decoder
  import bcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ins_valid = 1'b0;
  logic wr_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wr_word = 32'h0;
  logic [31:0] ins_bytes;
  logic width_bit = 1'b0;
  logic string_dst = 1'b0;
  bcd_state_t cpu_state = '0;
  bcd_dec_t dec_out;
  logic dec_valid;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  // Memory on the far side of the fetch path
  bcd_mem_model mem (.clk(clk), .wr_en(wr_en), .addr(addr),
    .wr_word(wr_word), .rd_en(ins_valid), .bytes(ins_bytes));

  bcd_decoder dut (.CORE_CLK(clk), .RST_N(rst_n), .INS_VALID(ins_valid),
    .INS_BYTES(ins_bytes), .WIDTH_BIT(width_bit),
    .STRING_DST(string_dst), .CPU_STATE(cpu_state),
    .DEC_OUT(dec_out), .DEC_VALID(dec_valid));

  // Clock and hang guard; a real run needs well under 1000 cycles
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Writing leaves wr_en high so two loads may follow each other
  task automatic ld(input logic [3:0] a, input logic [31:0] w);
    ins_valid = 1'b0;
    wr_en = 1'b1;
    addr = a;
    wr_word = w;
    @(posedge clk);
    #1;
  endtask

  // Present one slot; its result is visible on return
  task automatic go(input logic [3:0] a, input bcd_state_t s);
    wr_en = 1'b0;
    addr = a;
    cpu_state = s;
    ins_valid = 1'b1;
    @(posedge clk);
    #1;
  endtask

  task automatic run(input logic [31:0] w, input bcd_state_t s);
    ld(4'h0, w);
    go(4'h0, s);
  endtask

  task automatic br(bcd_kind_t k, logic t, logic [7:0] c);
    `CHK(dec_valid, 1'b1)
    `CHK(dec_out.kind, k)
    `CHK(dec_out.taken, t)
    `CHK(dec_out.add_m, t)
    `CHK(dec_out.clocks, c)
  endtask

  // All sixteen conditions under four flag mixes
  task automatic t_jcc();
    bcd_state_t s;
    logic [3:0] c;
    logic t;
    for (int f = 0; f < 4; f++)
    begin
      s = '0;
      s.ovf = f[0];
      s.zero = f[1];
      s.carry = f[0] ^ f[1];
      s.sign = f[1];
      s.parity = f[0];
      for (int i = 0; i < 16; i++)
      begin
        c = i[3:0];
        case (c[3:1])
          3'h0: t = s.ovf;
          3'h1: t = s.carry;
          3'h2: t = s.zero;
          3'h3: t = s.carry | s.zero;
          3'h4: t = s.sign;
          3'h5: t = s.parity;
          3'h6: t = s.sign ^ s.ovf;
          default: t = s.zero | (s.sign ^ s.ovf);
        endcase
        t = t ^ c[0];
        run({24'h0, 4'h7, c}, s);
        br(BCD_K_JCC, t, t ? 8'h07 : 8'h03);
      end
    end
    $display("conditional jump test done");
  endtask

  // Loop family, count one before decrement ends the loop
  task automatic t_loop();
    bcd_state_t s;
    logic t;
    bcd_kind_t ks[4] = '{BCD_K_LOOPNE, BCD_K_LOOPEQ, BCD_K_LOOP, BCD_K_JCZ};
    for (int i = 0; i < 16; i++)
    begin
      s = '0;
      s.zero = i[1];
      if (i[3:2] == 2'h3)
        s.count_is_zero = i[0];
      else
        s.count_is_one = i[0];
      case (i[3:2])
        2'h0: t = !i[0] && !i[1];
        2'h1: t = !i[0] && i[1];
        2'h2: t = !i[0];
        default: t = i[0];
      endcase
      run({24'h0, 6'h38, i[3:2]}, s);
      br(ks[i[3:2]], t, t ? 8'h08 : 8'h04);
    end
    $display("loop test done");
  endtask

  // Overflow trap both ways, range check in and out of range
  task automatic t_trap();
    bcd_state_t s;
    s = '0;
    run(32'h0000_00CE, s);
    br(BCD_K_OVTRAP, 1'b0, 8'h03);
    s.ovf = 1'b1;
    run(32'h0000_00CE, s);
    br(BCD_K_OVTRAP, 1'b1, 8'h18);
    `CHK(dec_out.vector, 8'h04)
    s = '0;
    s.range_ok = 1'b1;
    run(32'h0000_0062, s);
    `CHK(dec_out.clocks, 8'h0D)
    s.range_ok = 1'b0;
    run(32'h0000_0062, s);
    `CHK(dec_out.vector, 8'h05)
    `CHK(dec_out.clocks, 8'h17)
    $display("trap test done");
  endtask

  // Return costs; nested task in real mode must not switch tasks
  task automatic t_ret();
    bcd_state_t s;
    logic [7:0] e[5] = '{8'h11, 8'h1F, 8'h37, 8'hA9, 8'hA9};
    for (int i = 0; i < 5; i++)
    begin
      s = '0;
      s.prot_mode = (i > 0);
      s.priv_change = (i == 2 || i == 4);
      s.nested_task_flag = (i != 1 && i != 2);
      run(32'h0000_00CF, s);
      `CHK(dec_out.kind, BCD_K_INTERRUPT_RETURN)
      `CHK(dec_out.clocks, e[i])
      `CHK(dec_out.add_m, 1'b1)
    end
    $display("return test done");
  endtask

  // Flag opcodes, only the mask operation takes three clocks
  task automatic t_flags();
    logic [7:0] op[7] = '{8'hF8, 8'hF5, 8'hF9, 8'hFC, 8'hFD, 8'hFA, 8'hFB};
    for (int i = 0; i < 7; i++)
    begin
      run({24'h0, op[i]}, '0);
      `CHK(dec_out.flag_op, 3'(i + 1))
      `CHK(dec_out.clocks, (i == 5) ? 8'h03 : 8'h02)
    end
    $display("flag test done");
  endtask

  // Escape opcodes and descriptor table selection
  task automatic t_esc_tbl();
    logic [2:0] r[4] = '{3'h2, 3'h0, 3'h3, 3'h1};
    bcd_kind_t k[4] = '{BCD_K_GLOAD, BCD_K_GSTORE, BCD_K_VLOAD, BCD_K_VSTORE};
    for (int i = 0; i < 8; i++)
    begin
      run({16'h0, 2'h0, ~i[2:0], 3'h0, 5'h1B, i[2:0]}, '0);
      `CHK(dec_out.ext_op, {i[2:0], ~i[2:0]})
      `CHK({dec_out.clocks, dec_out.clocks_max}, 16'h0914)
    end
    for (int i = 0; i < 4; i++)
    begin
      run({8'h0, 2'h0, r[i], 3'h0, 16'h010F}, '0);
      `CHK(dec_out.kind, k[i])
      if (i > 1)
        `CHK(dec_out.clocks, 8'h0C)
    end
    $display("escape and table test done");
  endtask

  // Mode and r/m forms on the range opcode, width bit alternating
  task automatic t_addr();
    bcd_state_t s;
    logic [7:0] m[6] = '{8'hDB, 8'h36, 8'h00, 8'h69, 8'h92, 8'h7E};
    logic [7:0] b[6] = '{8'h34, 8'h34, 8'h34, 8'h80, 8'h34, 8'h05};
    bcd_disp_t f[6] = '{BCD_D_NONE, BCD_D_DIRECT, BCD_D_NONE, BCD_D_BYTE,
      BCD_D_WORD, BCD_D_BYTE};
    logic [15:0] d[6] = '{16'h0, 16'h1234, 16'h0, 16'hFF80, 16'h1234,
      16'h0005};
    logic [1:0] g[6] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2};
    s = '0;
    s.range_ok = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      width_bit = i[0];
      run({8'h12, b[i], m[i], 8'h62}, s);
      `CHK(dec_out.reg_sel, {i[0], m[i][5:3]})
      `CHK(dec_out.rm_is_reg, (i == 0))
      if (i == 0)
        `CHK(dec_out.rm_reg, 3'h3)
      else
      begin
        `CHK(dec_out.disp_form, f[i])
        `CHK(dec_out.disp, d[i])
        `CHK(dec_out.seg, g[i])
      end
    end
    $display("addressing test done");
  endtask

  // Prefix then operand back to back; override lasts one instruction
  task automatic t_prefix();
    bcd_state_t s;
    s = '0;
    s.range_ok = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      string_dst = (i == 4);
      ld(4'h1, {24'h0, 3'h1, i[1:0] ^ {1'b0, i[2]}, 3'h6});
      ld(4'h2, 32'h0000_0062);
      go(4'h1, s);
      `CHK({dec_out.kind, dec_out.clocks}, {BCD_K_PREFIX, 8'h00})
      go(4'h2, s);
      if (i == 4)
        `CHK({dec_out.seg, dec_out.dst_seg}, 4'h0)
      else
        `CHK(dec_out.seg, i[1:0])
      run(32'h0000_0062, s);
      `CHK(dec_out.seg, string_dst ? 2'h0 : 2'h3)
    end
    string_dst = 1'b0;
    $display("prefix test done");
  endtask

  // Reset in mid-run must drop a pending override and the result
  task automatic t_reset();
    bcd_state_t s;
    s = '0;
    s.range_ok = 1'b1;
    ld(4'h1, 32'h0000_002E);
    go(4'h1, s);
    // Prefix stays presented so a missed reset would show up
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    `CHK(dec_valid, 1'b0)
    `CHK(dec_out.kind, BCD_K_NONE)
    rst_n = 1'b1;
    run(32'h0000_0062, s);
    `CHK(dec_out.seg, 2'h3)
    $display("reset test done");
  endtask

  // Reset for five cycles, then each scenario in turn
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_jcc();
    t_loop();
    t_trap();
    t_ret();
    t_flags();
    t_esc_tbl();
    t_addr();
    t_prefix();
    t_reset();
    end_of_test();
  end
endmodule
